// file: rtl/debug_pkg.sv
// constants and types shared by the core debug port logic
package debug_pkg;
  localparam int WORD_W = 32;
  localparam int IR_W   = 4;
  localparam int CHAIN_W = 4;
  localparam int ICE_ADDR_W = 5;
  localparam int ICE_DR_W = WORD_W + ICE_ADDR_W + 1;
  localparam int NUM_REGS = 16;
  // access port instructions
  localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
  localparam logic [IR_W-1:0] IR_SCAN_N  = 4'h2;
  localparam logic [IR_W-1:0] IR_RESTART = 4'h4;
  localparam logic [IR_W-1:0] IR_INTEST  = 4'hc;
  localparam logic [IR_W-1:0] IR_BYPASS  = 4'hf;
  localparam logic [CHAIN_W-1:0] CHAIN_DEBUG = 4'h1;
  localparam logic [CHAIN_W-1:0] CHAIN_WATCH = 4'h2;
  // watchpoint scan chain register addresses
  localparam logic [ICE_ADDR_W-1:0] ICE_STATUS = 5'h01;
  localparam logic [ICE_ADDR_W-1:0] WP0_AV = 5'h08;
  localparam logic [ICE_ADDR_W-1:0] WP0_AM = 5'h09;
  localparam logic [ICE_ADDR_W-1:0] WP0_DV = 5'h0a;
  localparam logic [ICE_ADDR_W-1:0] WP0_DM = 5'h0b;
  localparam logic [ICE_ADDR_W-1:0] WP0_CV = 5'h0c;
  localparam logic [ICE_ADDR_W-1:0] WP0_CM = 5'h0d;
  localparam int STAT_ACK_BIT  = 0;
  localparam int STAT_MREQ_BIT = 3;
  localparam int WP_ENABLE_BIT = 8;
  localparam int CTRL_W = 8;
  // instruction encodings
  localparam logic [WORD_W-1:0] NOP_OPCODE   = 32'he1a00000;
  localparam logic [WORD_W-1:0] STORE_OPCODE = 32'he58e0000;
  localparam logic [WORD_W-1:0] STORE_MASK   = 32'hffff0fff;
  localparam int REG_IDX_LSB = 12;
  localparam int BASE_REG = 14;
  localparam logic [WORD_W-1:0] INSTR_LEN = 32'h00000004;
  localparam logic [WORD_W-1:0] PC_EXEC_OFS = 32'h00000008;
  // software register port
  localparam int REG_ADDR_W = 8;
  localparam logic [REG_ADDR_W-1:0] OFF_CORE_REG = 8'h00;
  localparam logic [REG_ADDR_W-1:0] OFF_STATUS   = 8'h40;
  localparam logic [REG_ADDR_W-1:0] OFF_PC       = 8'h44;
  localparam logic [REG_ADDR_W-1:0] OFF_BUS_DATA = 8'h48;
  localparam logic [REG_ADDR_W-1:0] OFF_BUS_ADDR = 8'h4c;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_e;
endpackage

// file: rtl/core_debug_port.sv
// core debug logic behind the four-wire test access port
// Notes on behaviour
// RL1 - host selects the watchpoint scan chain before writing watchpoint 0
// RL2 - host zeroes watchpoint 0 address value, mask 0xFFFFFFF ignores address
// RL3 - host zeroes watchpoint 0 data value, mask 0xFFFFFFF ignores data
// RL4 - host writes 0x00000100 to watchpoint 0 control value to enable it
// RL5 - host writes 0xFFFFFF7 to control mask: trigger on fetch only
// RL6 - host polls debug status until core shows debug state
// RL7 - host disables watchpoint 0 by zeroing control value once halted
// RL8 - host may reset the access port logic after the core stops
// RL9 - host selects scan chain 1 and shifts a full 32-bit instruction
// RL10 - no-operation fill code is the move 0xE1A00000
// RL11 - instruction enters pipeline at Run-Test/Idle; debug clock made there
// RL12 - two more pushes follow a no-operation before it executes
// RL13 - host fills unused pipeline slots with the no-operation code
// RL14 - register read uses store opcode 0xE58E0000, index in bits 12-15
// RL15 - register reads run only at debug clock speed, no restart
// RL16 - store: fetch, decode, execute at pc+2L, then alu address with Rd
// RL17 - cycle 4 drives register value at debug clock falling edge
// RL18 - instruction length in address arithmetic is 4 bytes
// RL19 - host treats system-speed work done on debug ack and request flag
// RL20 - host halts the core before any debug request
// RL21 - host shifts captured word out of chain 1 as read result
`timescale 1ns/1ps
module core_debug_port
  import debug_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // test access port pins
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo,
  // running core bus activity, same clock
  input  wire logic                  run_valid,
  input  wire logic [WORD_W-1:0]     run_addr,
  input  wire logic [WORD_W-1:0]     run_data,
  input  wire logic [CTRL_W-1:0]     run_ctrl,
  // debug state and debug bus
  output logic                       debug_acknowledge_flag,
  output logic                       memory_request_flag_low,
  output logic                       core_debug_clock,
  output logic [WORD_W-1:0]          core_bus_addr,
  output logic [WORD_W-1:0]          core_bus_data,
  // software register port
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [WORD_W-1:0]     reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic [WORD_W-1:0]          reg_rdata
);

  logic [2:0]            tck_sync;
  logic [1:0]            tms_sync;
  logic [1:0]            tdi_sync;
  logic                  tck_rise;
  logic                  tck_fall;
  tap_state_e            tap_state;
  tap_state_e            next_tap_state;
  logic [IR_W-1:0]       ir;
  logic [IR_W-1:0]       ir_sr;
  logic [CHAIN_W-1:0]    chain;
  logic [CHAIN_W-1:0]    chain_sr;
  logic [WORD_W-1:0]     dbg_sr;
  logic [WORD_W-1:0]     dbg_capture;
  logic [3:0]            store_rd;
  logic [ICE_DR_W-1:0]   ice_sr;
  logic [ICE_ADDR_W-1:0] ice_addr;
  logic                  bypass_sr;
  logic [WORD_W-1:0]     wp_av, wp_am, wp_dv, wp_dm, wp_cv, wp_cm;
  logic [WORD_W-1:0]     core_reg [NUM_REGS];
  logic [WORD_W-1:0]     pc;
  logic [WORD_W-1:0]     pipe_f, pipe_d, pipe_e;
  logic                  store_exec;
  logic                  store_data_due;
  logic                  push;
  logic                  restart;
  logic                  wp_hit;

  function automatic logic masked_eq(input logic [WORD_W-1:0] val,
                                     input logic [WORD_W-1:0] ref_v,
                                     input logic [WORD_W-1:0] mask);
    return ((val ^ ref_v) & ~mask) == '0;
  endfunction

  function automatic logic is_store(input logic [WORD_W-1:0] instr);
    return (instr & STORE_MASK) == STORE_OPCODE;
  endfunction

  function automatic logic [3:0] reg_index(input logic [WORD_W-1:0] instr);
    return instr[REG_IDX_LSB +: 4];
  endfunction

  // pins from outside: two flops before use; third flop only finds edges
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tck_sync <= '0;
      tms_sync <= '0;
      tdi_sync <= '0;
    end else begin
      tck_sync <= {tck_sync[1:0], tck};
      tms_sync <= {tms_sync[0], tms};
      tdi_sync <= {tdi_sync[0], tdi};
    end
  end

  assign tck_rise = tck_sync[1] & ~tck_sync[2];
  assign tck_fall = ~tck_sync[1] & tck_sync[2];

  always_comb begin
    next_tap_state = tap_state;
    case (tap_state)
      TLR:    next_tap_state = tms_sync[1] ? TLR : RTI;
      RTI:    next_tap_state = tms_sync[1] ? SEL_DR : RTI;
      SEL_DR: next_tap_state = tms_sync[1] ? SEL_IR : CAP_DR;
      CAP_DR: next_tap_state = tms_sync[1] ? EX1_DR : SH_DR;
      SH_DR:  next_tap_state = tms_sync[1] ? EX1_DR : SH_DR;
      EX1_DR: next_tap_state = tms_sync[1] ? UPD_DR : PAU_DR;
      PAU_DR: next_tap_state = tms_sync[1] ? EX2_DR : PAU_DR;
      EX2_DR: next_tap_state = tms_sync[1] ? UPD_DR : SH_DR;
      UPD_DR: next_tap_state = tms_sync[1] ? SEL_DR : RTI;
      SEL_IR: next_tap_state = tms_sync[1] ? TLR : CAP_IR;
      CAP_IR: next_tap_state = tms_sync[1] ? EX1_IR : SH_IR;
      SH_IR:  next_tap_state = tms_sync[1] ? EX1_IR : SH_IR;
      EX1_IR: next_tap_state = tms_sync[1] ? UPD_IR : PAU_IR;
      PAU_IR: next_tap_state = tms_sync[1] ? EX2_IR : PAU_IR;
      EX2_IR: next_tap_state = tms_sync[1] ? UPD_IR : SH_IR;
      UPD_IR: next_tap_state = tms_sync[1] ? SEL_DR : RTI;
      default: next_tap_state = TLR;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) tap_state <= TLR;
    else if (tck_rise) tap_state <= next_tap_state;
  end

  // a step happens on entry to Run-Test/Idle straight after a chain 1
  // update; both use the freshly shifted word, since a registered copy
  // would only turn over at that same edge
  assign push = tck_rise && next_tap_state == RTI && tap_state == UPD_DR
                && ir == IR_INTEST && chain == CHAIN_DEBUG; // RL11
  assign restart = tck_rise && next_tap_state == RTI && tap_state == UPD_IR
                   && ir_sr == IR_RESTART;

  // instruction register; logic reset leaves bypass selected
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ir    <= IR_BYPASS;
      ir_sr <= '0;
    end else if (tck_rise) begin
      case (tap_state)
        TLR:     ir <= IR_BYPASS; // RL8
        CAP_IR:  ir_sr <= {{(IR_W-1){1'b0}}, 1'b1};
        SH_IR:   ir_sr <= {tdi_sync[1], ir_sr[IR_W-1:1]};
        UPD_IR:  ir <= ir_sr;
        default: ir <= ir;
      endcase
    end
  end

  // scan chain select and bypass
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      chain     <= '0;
      chain_sr  <= '0;
      bypass_sr <= 1'b0;
    end else if (tck_rise) begin
      if (tap_state == TLR) chain <= '0;
      if (tap_state == CAP_DR) bypass_sr <= 1'b0;
      if (tap_state == SH_DR) begin
        bypass_sr <= tdi_sync[1];
        if (ir == IR_SCAN_N) chain_sr <= {tdi_sync[1], chain_sr[CHAIN_W-1:1]};
      end
      if (tap_state == UPD_DR && ir == IR_SCAN_N) chain <= chain_sr; // RL1
    end
  end

  // debug chain: instruction in, stored register word out
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dbg_sr <= '0;
    end else if (tck_rise && ir == IR_INTEST && chain == CHAIN_DEBUG) begin
      case (tap_state)
        CAP_DR:  dbg_sr <= dbg_capture; // RL21
        SH_DR:   dbg_sr <= {tdi_sync[1], dbg_sr[WORD_W-1:1]}; // RL9
        default: dbg_sr <= dbg_sr;
      endcase
    end
  end

  // watchpoint chain: 32 data, 5 address, 1 write flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ice_sr   <= '0;
      ice_addr <= '0;
      wp_av    <= '0;
      wp_am    <= '0;
      wp_dv    <= '0;
      wp_dm    <= '0;
      wp_cv    <= '0;
      wp_cm    <= '0;
    end else if (tck_rise && ir == IR_INTEST && chain == CHAIN_WATCH) begin
      case (tap_state)
        CAP_DR: begin
          ice_sr <= '0;
          case (ice_addr)
            ICE_STATUS: begin
              ice_sr[STAT_ACK_BIT]  <= debug_acknowledge_flag; // RL6
              ice_sr[STAT_MREQ_BIT] <= memory_request_flag_low; // RL19
            end
            WP0_AV:  ice_sr[WORD_W-1:0] <= wp_av;
            WP0_AM:  ice_sr[WORD_W-1:0] <= wp_am;
            WP0_DV:  ice_sr[WORD_W-1:0] <= wp_dv;
            WP0_DM:  ice_sr[WORD_W-1:0] <= wp_dm;
            WP0_CV:  ice_sr[WORD_W-1:0] <= wp_cv;
            WP0_CM:  ice_sr[WORD_W-1:0] <= wp_cm;
            default: ice_sr[WORD_W-1:0] <= '0;
          endcase
        end
        SH_DR: ice_sr <= {tdi_sync[1], ice_sr[ICE_DR_W-1:1]};
        UPD_DR: begin
          ice_addr <= ice_sr[WORD_W +: ICE_ADDR_W];
          if (ice_sr[ICE_DR_W-1]) begin
            case (ice_sr[WORD_W +: ICE_ADDR_W])
              WP0_AV:  wp_av <= ice_sr[WORD_W-1:0]; // RL2
              WP0_AM:  wp_am <= ice_sr[WORD_W-1:0]; // RL2
              WP0_DV:  wp_dv <= ice_sr[WORD_W-1:0]; // RL3
              WP0_DM:  wp_dm <= ice_sr[WORD_W-1:0]; // RL3
              WP0_CV:  wp_cv <= ice_sr[WORD_W-1:0]; // RL4
              WP0_CM:  wp_cm <= ice_sr[WORD_W-1:0]; // RL5
              default: wp_cv <= wp_cv;
            endcase
          end
        end
        default: ice_sr <= ice_sr;
      endcase
    end
  end

  // masks of 0xfffffff leave the top nibble compared against zero
  assign wp_hit = run_valid && wp_cv[WP_ENABLE_BIT] // RL4 RL7
                  && masked_eq(run_addr, wp_av, wp_am) // RL2
                  && masked_eq(run_data, wp_dv, wp_dm) // RL3
                  && masked_eq({{(WORD_W-CTRL_W){1'b0}}, run_ctrl},
                               wp_cv, wp_cm); // RL5

  // halt on a watchpoint hit; only a restart leaves debug state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      debug_acknowledge_flag  <= 1'b0;
      memory_request_flag_low <= 1'b1;
    end else begin
      if (wp_hit && !debug_acknowledge_flag) debug_acknowledge_flag <= 1'b1;
      else if (restart) debug_acknowledge_flag <= 1'b0;
      memory_request_flag_low <= ~(run_valid & ~debug_acknowledge_flag);
    end
  end

  // three-stage pipeline stepped once per debug clock
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pipe_f           <= NOP_OPCODE; // RL10
      pipe_d           <= NOP_OPCODE;
      pipe_e           <= NOP_OPCODE;
      store_exec       <= 1'b0;
      store_data_due   <= 1'b0;
      store_rd         <= '0;
      core_debug_clock <= 1'b0;
      core_bus_addr    <= '0;
      core_bus_data    <= '0;
      dbg_capture      <= '0;
      pc               <= '0;
    end else begin
      core_debug_clock <= push; // RL11
      if (push) begin
        pipe_f     <= dbg_sr;
        pipe_d     <= pipe_f; // RL12
        pipe_e     <= pipe_d;
        pc         <= pc + INSTR_LEN; // RL18
        store_exec <= is_store(pipe_d); // RL14
        if (is_store(pipe_d)) begin
          // the stage turns over again before the data cycle: keep the index
          store_rd      <= reg_index(pipe_d); // RL14
          core_bus_addr <= pc + INSTR_LEN + PC_EXEC_OFS; // RL16
        end
        if (store_exec) begin
          core_bus_addr  <= core_reg[BASE_REG]; // RL16
          store_data_due <= 1'b1;
        end
      end else if (store_data_due && core_debug_clock) begin
        // debug clock falls now: drive and keep the stored register
        core_bus_data  <= core_reg[store_rd]; // RL17
        dbg_capture    <= core_reg[store_rd]; // RL15
        store_data_due <= 1'b0;
      end
      if (reg_write && reg_addr == OFF_PC) pc <= reg_wdata;
    end
  end

  // test data out changes on falling test clock
  always_ff @(posedge sys_clk) begin
    if (!reset_n) tdo <= 1'b0;
    else if (tck_fall) begin
      if (tap_state == SH_IR) tdo <= ir_sr[0];
      else if (tap_state != SH_DR) tdo <= tdo;
      else if (ir == IR_SCAN_N) tdo <= chain_sr[0];
      else if (ir == IR_INTEST && chain == CHAIN_DEBUG) tdo <= dbg_sr[0];
      else if (ir == IR_INTEST && chain == CHAIN_WATCH) tdo <= ice_sr[0];
      else tdo <= bypass_sr;
    end
  end

  // core registers are preset by software; no reset on the array
  always_ff @(posedge sys_clk) begin
    if (reg_write && reg_addr < OFF_STATUS)
      core_reg[reg_addr[5:2]] <= reg_wdata;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) reg_rdata <= '0;
    else if (reg_read) begin
      if (reg_addr < OFF_STATUS && reg_addr[1:0] == 2'b00)
        reg_rdata <= core_reg[reg_addr[5:2]];
      else if (reg_addr == OFF_STATUS)
        reg_rdata <= {{(WORD_W-STAT_MREQ_BIT-1){1'b0}},
                      memory_request_flag_low, 2'b00,
                      debug_acknowledge_flag};
      else if (reg_addr == OFF_PC) reg_rdata <= pc;
      else if (reg_addr == OFF_BUS_DATA) reg_rdata <= core_bus_data;
      else if (reg_addr == OFF_BUS_ADDR) reg_rdata <= core_bus_addr;
      else reg_rdata <= '0;
    end else reg_rdata <= '0;
  end

endmodule // core_debug_port

// file: dv/core_debug_port_assertions.sv
// concurrent checks on the core debug port pins
`timescale 1ns/1ps
module core_debug_port_assertions
  import debug_pkg::*;
(
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  reset_n,
  // access port and debug state
  input wire logic                  tck,
  input wire logic                  tdo,
  input wire logic                  debug_acknowledge_flag,
  input wire logic                  memory_request_flag_low,
  input wire logic                  core_debug_clock,
  input wire logic [WORD_W-1:0]     core_bus_addr,
  input wire logic [WORD_W-1:0]     core_bus_data,
  // register port
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic                  reg_read,
  input wire logic [WORD_W-1:0]     reg_rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_step;
    core_debug_clock ##1 !core_debug_clock;
  endsequence
  // a new step needs a fresh pass through the data path, so it cannot recur for seven cycles
  sequence s_quiet;
    !core_debug_clock [*7];
  endsequence

  a_step_single: assert property (core_debug_clock |-> s_step ##0 s_quiet)
    else $error("debug clock step not a lone one-cycle pulse");
  a_data_on_fall: assert property (
    $changed(core_bus_data) |-> $fell(core_debug_clock))
    else $error("bus data moved away from the debug clock fall");
  a_addr_on_step: assert property (
    $changed(core_bus_addr) |-> core_debug_clock)
    else $error("bus address moved outside a pipeline step");
  a_step_stays_halted: assert property (
    core_debug_clock && debug_acknowledge_flag |=> debug_acknowledge_flag)
    else $error("pipeline step left debug state");
  a_tdo_low_tck: assert property ($changed(tdo) |-> !tck)
    else $error("tdo changed while tck high");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == '0)
    else $error("read data not zero outside read answer");
  a_status_read: assert property (
    reg_read && reg_addr == OFF_STATUS |=>
      reg_rdata[STAT_ACK_BIT] == $past(debug_acknowledge_flag) &&
      reg_rdata[STAT_MREQ_BIT] == $past(memory_request_flag_low))
    else $error("status read does not show debug flags");
  a_unmapped_zero: assert property (
    reg_read && (reg_addr > OFF_BUS_ADDR || reg_addr[1:0] != 2'h0) |=>
      reg_rdata == '0)
    else $error("unmapped read returned data");
endmodule // core_debug_port_assertions

bind core_debug_port core_debug_port_assertions
  core_debug_port_assertions_inst (
  .sys_clk, .reset_n, .tck, .tdo, .debug_acknowledge_flag,
  .memory_request_flag_low, .core_debug_clock, .core_bus_addr,
  .core_bus_data, .reg_addr, .reg_read, .reg_rdata);

// file: dv/jtag_host_model.sv
// behavioural debug host driving tck, tms and tdi and sampling tdo
`timescale 1ns/1ps
module jtag_host_model
  import debug_pkg::*;
(
  // access port pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // tck rests low between frames; pins change only while tck is low
  task automatic clk(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #16 tck = 1'b1;
    o = tdo;
    #16 tck = 1'b0;
  endtask

  task automatic scan(input logic ir, input logic [37:0] din, input int n,
                      output logic [37:0] dout);
    logic o;
    dout = '0;
    // odd offset keeps tck edges drifting against sys_clk
    #1.3;
    clk(1'b1, tdi, o);
    if (ir) clk(1'b1, tdi, o);
    clk(1'b0, tdi, o);
    clk(1'b0, tdi, o);
    for (int i = 0; i < n; i++) begin
      clk(i == n - 1, din[i], o);
      dout[i] = o;
    end
    // data line is don't-care now, so it does not keep the last bit
    clk(1'b1, ~tdi, o);
    clk(1'b0, ~tdi, o);
  endtask

  task automatic reset_tap();
    logic o;
    repeat (5) clk(1'b1, tdi, o);
    clk(1'b0, tdi, o);
  endtask

  task automatic select_chain(input logic [CHAIN_W-1:0] c);
    logic [37:0] x;
    scan(1'b1, 38'(IR_SCAN_N), IR_W, x);
    scan(1'b0, 38'(c), CHAIN_W, x);
    scan(1'b1, 38'(IR_INTEST), IR_W, x);
  endtask

  task automatic ice_wr(input logic [ICE_ADDR_W-1:0] a,
                        input logic [WORD_W-1:0] d);
    logic [37:0] x;
    scan(1'b0, {1'b1, a, d}, ICE_DR_W, x);
  endtask

  task automatic arm_halt();
    select_chain(CHAIN_WATCH);
    ice_wr(WP0_AV, 32'h00000000);
    ice_wr(WP0_AM, 32'h0fffffff);
    ice_wr(WP0_DV, 32'h00000000);
    ice_wr(WP0_DM, 32'h0fffffff);
    ice_wr(WP0_CV, 32'h00000100);
    ice_wr(WP0_CM, 32'h0ffffff7);
  endtask

  task automatic wait_halt(output logic ok);
    logic [37:0] x;
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      scan(1'b0, {1'b0, ICE_STATUS, 32'h0}, ICE_DR_W, x);
      scan(1'b0, {1'b0, ICE_STATUS, 32'h0}, ICE_DR_W, x);
      ok = (x[STAT_ACK_BIT] === 1'b1);
    end
  endtask

  task automatic push(input logic [WORD_W-1:0] op,
                      output logic [WORD_W-1:0] q);
    logic [37:0] x;
    scan(1'b0, 38'(op), WORD_W, x);
    q = x[WORD_W-1:0];
  endtask
endmodule // jtag_host_model

// file: dv/core_debug_port_tb_top.sv
// self-checking bench for the core debug port
`timescale 1ns/1ps
module core_debug_port_tb_top
  import debug_pkg::*;
;
  logic                  sys_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  tck, tms, tdi, tdo;
  logic                  run_valid = 1'b0;
  logic [WORD_W-1:0]     run_addr = 32'h00001000;
  logic [WORD_W-1:0]     run_data = 32'h00000055;
  logic [CTRL_W-1:0]     run_ctrl = 8'h08;
  logic                  debug_acknowledge_flag, memory_request_flag_low;
  logic                  core_debug_clock;
  logic [WORD_W-1:0]     core_bus_addr, core_bus_data, reg_rdata;
  logic [WORD_W-1:0]     reg_wdata = '0;
  logic [REG_ADDR_W-1:0] reg_addr = '0;
  logic                  reg_write = 1'b0;
  logic                  reg_read = 1'b0;
  logic [WORD_W-1:0]     regs [NUM_REGS];
  int                    n_fail = 0;
  int                    n_compared = 0;

  always #2 sys_clk = ~sys_clk;

  core_debug_port core_debug_port_inst (
    .sys_clk, .reset_n, .tck, .tms, .tdi, .tdo, .run_valid, .run_addr,
    .run_data, .run_ctrl, .debug_acknowledge_flag, .memory_request_flag_low,
    .core_debug_clock, .core_bus_addr, .core_bus_data, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  jtag_host_model jtag_host_model_inst (.tck, .tms, .tdi, .tdo);

  task automatic chk(input logic [WORD_W-1:0] seen,
                     input logic [WORD_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [WORD_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [WORD_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic test_regs();
    logic [WORD_W-1:0] d;
    for (int i = 0; i < NUM_REGS; i++) begin
      regs[i] = 32'hc3a50000 + 32'(i) * 32'h00010111;
      reg_wr(8'(i * 4), regs[i]);
    end
    for (int i = 0; i < NUM_REGS; i++) begin
      reg_rd(8'(i * 4), d);
      chk(d, regs[i]);
    end
    reg_wr(OFF_PC, 32'h00000100);
    reg_rd(OFF_PC, d);
    chk(d, 32'h00000100);
    // status is read-only: the write must not disturb the flags
    reg_wr(OFF_STATUS, 32'hffffffff);
    reg_rd(OFF_STATUS, d);
    chk(d & 32'h00000009, 32'h00000008);
    reg_wr(OFF_BUS_DATA, 32'hffffffff);
    @(negedge sys_clk);
    chk(core_bus_data, 32'h00000000);
    reg_rd(8'h80, d);
    chk(d, 32'h00000000);
    reg_rd(8'h02, d);
    chk(d, 32'h00000000);
    $display("test_regs done");
  endtask

  task automatic test_halt();
    logic ok;
    logic [WORD_W-1:0] d;
    // the port leaves reset in Test-Logic-Reset; walk it to Run-Test/Idle
    jtag_host_model_inst.reset_tap();
    jtag_host_model_inst.arm_halt();
    @(posedge sys_clk);
    run_valid <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk(32'(debug_acknowledge_flag), 32'h0);
    run_ctrl <= 8'h00;
    jtag_host_model_inst.wait_halt(ok);
    chk(32'(ok), 32'h1);
    @(posedge sys_clk);
    run_valid <= 1'b0;
    jtag_host_model_inst.ice_wr(WP0_CV, 32'h00000000);
    jtag_host_model_inst.reset_tap();
    reg_rd(OFF_STATUS, d);
    chk(d & 32'h00000009, 32'h00000009);
    $display("test_halt done");
  endtask

  task automatic test_read();
    logic [WORD_W-1:0] q;
    logic [WORD_W-1:0] pc;
    int idx [3] = '{0, 7, 13};
    jtag_host_model_inst.select_chain(CHAIN_DEBUG);
    foreach (idx[k]) begin
      jtag_host_model_inst.push(
        STORE_OPCODE | (32'(idx[k]) << REG_IDX_LSB), q);
      jtag_host_model_inst.push(NOP_OPCODE, q);
      jtag_host_model_inst.push(NOP_OPCODE, q);
      repeat (8) @(posedge sys_clk);
      reg_rd(OFF_PC, pc);
      chk(core_bus_addr, pc + 2 * INSTR_LEN);
      jtag_host_model_inst.push(NOP_OPCODE, q);
      repeat (8) @(posedge sys_clk);
      chk(core_bus_addr, regs[BASE_REG]);
      chk(core_bus_data, regs[idx[k]]);
      jtag_host_model_inst.push(NOP_OPCODE, q);
      chk(q, regs[idx[k]]);
    end
    $display("test_read done");
  endtask

  task automatic test_restart();
    logic [37:0] x;
    logic [WORD_W-1:0] d;
    jtag_host_model_inst.scan(1'b1, 38'(IR_RESTART), IR_W, x);
    reg_rd(OFF_STATUS, d);
    chk(d & 32'h00000009, 32'h00000008);
    $display("test_restart done");
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    test_regs();
    test_halt();
    test_read();
    test_restart();
    end_sim();
  end

  // the whole sequence needs well under 100 us of link traffic
  initial begin
    #300000;
    n_fail++;
    end_sim();
  end
endmodule // core_debug_port_tb_top
